// ===== dv/mlc_cpu_model.sv
/*
   cpu core model: instruction boundary every fourth cycle, return ten cycles after a vector.
   assumes the controller core on the same clock and reset.
*/
`timescale 1ns/100ps
module mlc_cpu_model (
   // clock, reset
   input  wire logic       clk_sys,
   input  wire logic       resetn,
   // controller side
   input  wire logic       gie,
   input  wire logic       vec_valid,
   output mlc_pkg::mlc_cpu_t cpu
);
   import mlc_pkg::*;
   logic [1:0] step_ff;
   logic [3:0] hold_ff;
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         step_ff <= 2'h0;
         hold_ff <= 4'h0;
      end else begin
         step_ff <= step_ff + 2'h1;
         hold_ff <= vec_valid ? 4'hA : (hold_ff != 4'h0) ? hold_ff - 4'h1 : 4'h0;
      end
   end
   // multicycle instructions end only at every fourth edge
   assign cpu = '{gie, (step_ff == 2'h0), (hold_ff == 4'h1), 1'b0, 1'b1};
endmodule

// ===== dv/test_multilevel_interrupt_controller.sv
/*
   bench of the request controller: register checks and random low-level bursts.
   assumes mlc_core and mlc_cpu_model.
*/
`timescale 1ns/100ps
module test_multilevel_interrupt_controller;
   import mlc_pkg::*;
   logic         clk_sys = 1'b0;
   logic         resetn = 1'b0;
   logic         reg_wr = 1'b0;
   logic         reg_rd = 1'b0;
   logic         gie = 1'b0;
   logic         fuse = 1'b0;
   logic         m_rr;
   logic [7:0]   reg_addr = 8'h00;
   logic [7:0]   reg_wdata = 8'h00;
   logic [7:0]   src_event = 8'h00;
   logic [7:0]   m_pend = 8'h00;
   logic [7:0]   nmi_src = 8'h00;
   logic         ret_done;
   int           ret_seen = 0;
   int           vec_seen = 0;
   logic [7:0]   reg_rdata;
   logic [15:0]  reset_address;
   mlc_lvl_arr_t src_level = '0;
   mlc_cpu_t     cpu;
   mlc_vec_t     vec;
   int           fail_count = 0;
   int           total_checks = 0;
   int           cycles = 0;
   int           m_last = 0;
   always #20 clk_sys = ~clk_sys;
   mlc_core i_mlc_core (.clk_sys(clk_sys), .resetn(resetn), .ce(1'b1), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .src_event(src_event), .src_is_nmi(nmi_src), .src_auto_clear(8'hFF),
      .src_access_clear(8'h00), .src_level(src_level), .cpu(cpu), .boot_reset_fuse(fuse),
      .boot_reset_addr(16'h4000), .vec(vec), .reset_address(reset_address), .ret_done(ret_done));
   mlc_cpu_model i_mlc_cpu_model (.clk_sys(clk_sys), .resetn(resetn), .gie(gie),
      .vec_valid(vec.valid), .cpu(cpu));
   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 check({8'h00, reg_rdata}, {8'h00, e}, "read data");
      @(posedge clk_sys);
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // ************************************************************
   // model: next low vector from pending set and rotation start
   // ************************************************************
   always @(posedge clk_sys) begin
      int s;
      int e;
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         finish_test();
      end
      if (resetn && ret_done === 1'b1) ret_seen++;
      if (resetn && vec.valid === 1'b1) begin
         vec_seen++;
         s = m_rr ? m_last + 1 : 0;
         e = 0;
         for (int k = 7; k >= 0; k--)
            if (m_pend[(s + k) % 8]) e = (s + k) % 8;
         check(16'(vec.idx), 16'(e), "vector index");
         check(vec.addr, 16'h0002 + 16'(2 * e), "vector address");
         check(16'(vec.is_nmi), 16'(nmi_src[e]), "unmaskable mark");
         m_pend[e] = 1'b0;
         if (m_rr && !nmi_src[e] && src_level[e] == LVL_LO) m_last = e;
      end
   end
   initial begin
      void'($urandom(41397));
      repeat (16) @(posedge clk_sys);
      resetn <= 1'b1;
      @(posedge clk_sys);
      rd(OFS_STATUS, 8'h00);
      rd(OFS_CTRL, 8'h00);
      rd(8'h7E, 8'h00);
      #1 check(reset_address, 16'h4000, "reset address");
      fuse <= 1'b1;
      src_level <= {8{LVL_LO}};
      src_event <= 8'h08;
      @(posedge clk_sys);
      src_event <= 8'h00;
      rd(OFS_FLAGS, 8'h08);
      wr(OFS_FLAGS, 8'h00);
      rd(OFS_FLAGS, 8'h08);
      wr(OFS_FLAGS, 8'h08);
      rd(OFS_FLAGS, 8'h00);
      #1 check(reset_address, 16'h0000, "reset address");
      @(posedge clk_sys);
      $display("register test done");
      for (int t = 0; t < 12; t++) begin
         m_rr = 1'($urandom_range(1));
         wr(OFS_CTRL, {m_rr, 6'h00, 1'b1});
         m_pend = 8'($urandom_range(255, 1));
         src_event <= m_pend;
         @(posedge clk_sys);
         src_event <= 8'h00;
         repeat (6) @(posedge clk_sys);
         rd(OFS_FLAGS, m_pend);
         gie <= 1'b1;
         for (int w = 0; w < 400 && m_pend != 8'h00; w++) @(posedge clk_sys);
         check({8'h00, m_pend}, 16'h0000, "pending served");
         gie <= 1'b0;
         repeat (24) @(posedge clk_sys);
         rd(OFS_STATUS, 8'h00);
         $display("burst %0d done", t);
      end
      // unmaskable source 7 beside high-level source 2, global enable off
      nmi_src <= 8'h80;
      wr(OFS_NMIEN, 8'h80);
      src_level[2] <= LVL_HI;
      m_pend = 8'h80;
      src_event <= 8'h84;
      @(posedge clk_sys);
      src_event <= 8'h00;
      wr(OFS_CTRL, 8'h04);
      for (int w = 0; w < 400 && m_pend != 8'h00; w++) @(posedge clk_sys);
      rd(OFS_STATUS, 8'h80);
      check({8'h00, m_pend}, 16'h0000, "unmaskable served");
      m_pend = 8'h04;
      wr(OFS_UNLOCK, UNLOCK_SIG);
      gie <= 1'b1;
      for (int w = 0; w < 400 && m_pend != 8'h00; w++) @(posedge clk_sys);
      rd(OFS_STATUS, 8'h04);
      check({8'h00, m_pend}, 16'h0000, "high served");
      gie <= 1'b0;
      repeat (24) @(posedge clk_sys);
      rd(OFS_STATUS, 8'h00);
      check(16'(ret_seen), 16'(vec_seen), "handler returns");
      $display("unmaskable test done");
      finish_test();
   end
endmodule

// ===== logic/mlc_core.sv
/*
   multilevel request controller core: pending flags, level arbitration, vector
   sequencing, handler return tracking and the software register port.
   assumes a cpu that pulses insn_done at instruction boundaries and handler_return_instruction on a return.
*/
// Strobed register access and the address map were left to the implementer.
//
// Summary of operation
// - a source event sets its pending flag whether or not the source is enabled
// - flags of auto-clear sources clear when their vector executes; others on access
// - writing one to a flag clears it; writing zero leaves it
// - requests behind higher priority work stay pending until they win
// - flags of disabled sources stay until enabled or cleared by software
// - flags stay while global enable is off, then are served by priority
// - correct unlock signature blocks acknowledgement for four cycles
// - enabled unmaskable requests ignore the global enable and never change it
// - nothing is acknowledged while an unmaskable handler executes
// - simultaneous unmaskable requests go lowest vector first
// - response takes three cycles: finish plus two push; jump takes three
// - a running multicycle instruction completes before vectoring
// - waking from sleep adds five cycles plus the start-up time
// - handler return takes four or five cycles by program counter width
// - each source gives a two-bit level: off, low, medium, high
// - higher levels preempt lower handlers, which resume after return
// - only the low level may use rotating order; others stay fixed
// - fixed order acknowledges the lowest pending vector of a level first
// - with rotation, the last acknowledged low vector becomes lowest priority
// - reset and vector base follow the boot fuse and vector select bit
// - status bit seven marks an unmaskable handler until its return
// - status bits two to zero mark executing levels, kept while preempted
// - per-level enable bits gate their levels, one cycle after clearing
// - rotating enable bit selects rotating or fixed low-level order
// - eight-bit register holds the last low vector; not reset by disabling rotation
// - one instruction runs between a return and the next acknowledgement
//
`timescale 1ns/100ps
module mlc_core (
   // clock, reset, enable
   input  wire logic                      clk_sys,
   input  wire logic                      resetn,
   input  wire logic                      ce,
   // register port
   input  wire logic [7:0]                reg_addr,
   input  wire logic [7:0]                reg_wdata,
   input  wire logic                      reg_wr,
   input  wire logic                      reg_rd,
   output logic [7:0]                     reg_rdata,
   // request sources
   input  wire logic [mlc_pkg::N_SRC-1:0] src_event,
   input  wire logic [mlc_pkg::N_SRC-1:0] src_is_nmi,
   input  wire logic [mlc_pkg::N_SRC-1:0] src_auto_clear,
   input  wire logic [mlc_pkg::N_SRC-1:0] src_access_clear,
   input  wire mlc_pkg::mlc_lvl_arr_t     src_level,
   // cpu side
   input  wire mlc_pkg::mlc_cpu_t         cpu,
   input  wire logic                      boot_reset_fuse,
   input  wire logic [15:0]               boot_reset_addr,
   output mlc_pkg::mlc_vec_t              vec,
   output logic [15:0]                    reset_address,
   output logic                           ret_done
);
   import mlc_pkg::*;

   typedef struct packed {
      logic [N_SRC-1:0] pend;
      logic [N_SRC-1:0] nmi_en;
      logic [7:0]       last_lo;
      mlc_ctrl_t        ctrl;
      mlc_exec_t        exec;
      mlc_state_t       st;
      logic [2:0]       cnt;
      logic [2:0]       blk;
      logic             sel_nmi;
      logic [1:0]       sel_lvl;
      logic [IDX_W-1:0] sel_idx;
      mlc_vec_t         vec;
      logic [15:0]      rst_addr;
      logic [7:0]       rdata;
      logic             ret_done;
   } mlc_regs_t;

   mlc_regs_t r_ff;
   mlc_regs_t nxt_r;

   // ************************************************************
   // request vectors per level
   // ************************************************************
   logic [N_SRC-1:0] req_nmi, req_hi, req_med, req_lo;
   logic             f_nmi, f_hi, f_med, f_lo;
   logic [IDX_W-1:0] i_nmi, i_hi, i_med, i_lo;
   logic [1:0]       cur_lvl;
   logic             take_ok, take, take_nmi;
   logic [1:0]       take_lvl;
   logic [IDX_W-1:0] take_idx;

   always_comb begin
      for (int i = 0; i < N_SRC; i++) begin
         // level and enable gating happens here, flags remain untouched
         req_nmi[i] = r_ff.pend[i] && src_is_nmi[i] && r_ff.nmi_en[i];
         req_hi[i]  = r_ff.pend[i] && !src_is_nmi[i] && lvl_req(src_level[i], LVL_HI, r_ff.ctrl);
         req_med[i] = r_ff.pend[i] && !src_is_nmi[i] && lvl_req(src_level[i], LVL_MED, r_ff.ctrl);
         req_lo[i]  = r_ff.pend[i] && !src_is_nmi[i] && lvl_req(src_level[i], LVL_LO, r_ff.ctrl);
      end
   end

   // fixed order for unmaskable, high and medium
   mlc_pick u_pick_nmi (.req(req_nmi), .rr_en(1'b0), .last(r_ff.last_lo), .found(f_nmi),
                        .idx(i_nmi));
   mlc_pick u_pick_hi  (.req(req_hi), .rr_en(1'b0), .last(r_ff.last_lo), .found(f_hi),
                        .idx(i_hi));
   mlc_pick u_pick_med (.req(req_med), .rr_en(1'b0), .last(r_ff.last_lo), .found(f_med),
                        .idx(i_med));
   // low level may rotate
   mlc_pick u_pick_lo  (.req(req_lo), .rr_en(r_ff.ctrl.rr_en), .last(r_ff.last_lo),
                        .found(f_lo), .idx(i_lo));

   // ************************************************************
   // arbitration
   // ************************************************************
   always_comb begin
      cur_lvl  = exec_level(r_ff.exec);
      // idle, no return pending, no unlock block, no unmaskable running
      take_ok  = ce && (r_ff.st == ST_IDLE) && !cpu.handler_return_instruction && (r_ff.blk == RST_CNT) &&
                 !r_ff.exec.nmi;
      // unmaskable requests skip the global enable
      take_nmi = take_ok && f_nmi;
      take     = 1'b0;
      take_lvl = LVL_OFF;
      take_idx = '0;
      if (take_nmi) begin
         take     = 1'b1;
         take_idx = i_nmi;
      end else if (take_ok && cpu.gie) begin
         // highest level above everything executing wins
         if (f_hi && (LVL_HI > cur_lvl)) begin
            take     = 1'b1;
            take_lvl = LVL_HI;
            take_idx = i_hi;
         end else if (f_med && (LVL_MED > cur_lvl)) begin
            take     = 1'b1;
            take_lvl = LVL_MED;
            take_idx = i_med;
         end else if (f_lo && (LVL_LO > cur_lvl)) begin
            take     = 1'b1;
            take_lvl = LVL_LO;
            take_idx = i_lo;
         end
      end
   end

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      logic [N_SRC-1:0] w1c;
      logic [N_SRC-1:0] vclr;
      logic [15:0]      base;
      w1c   = '0;
      vclr  = '0;
      base  = '0;
      nxt_r = r_ff;
      if (ce) begin
         nxt_r.vec.valid = 1'b0;
         nxt_r.ret_done  = 1'b0;
         nxt_r.rdata     = RST_BYTE;
         if (reg_wr && (reg_addr == OFS_FLAGS)) begin
            w1c = reg_wdata[N_SRC-1:0];
         end
         // reset placement follows the boot fuse
         nxt_r.rst_addr = boot_reset_fuse ? RESET_VEC : boot_reset_addr;
         base = r_ff.ctrl.vsel ? 16'(boot_reset_addr + VEC_BASE_OFS) : VEC_BASE_OFS;
         if (r_ff.blk != RST_CNT) begin
            nxt_r.blk = r_ff.blk - 3'h1;
         end
         if (reg_wr && (reg_addr == OFS_UNLOCK) && (reg_wdata == UNLOCK_SIG)) begin
            nxt_r.blk = BLOCK_CYC;
         end
         case (r_ff.st)
            ST_IDLE: begin
               if (cpu.handler_return_instruction && (r_ff.exec != '0)) begin
                  nxt_r.st  = ST_RET;
                  nxt_r.cnt = RET_CYC - 3'h1;
               end else if (take) begin
                  nxt_r.sel_nmi = take_nmi;
                  nxt_r.sel_lvl = take_lvl;
                  nxt_r.sel_idx = take_idx;
                  // the current instruction boundary counts as the finish cycle
                  if (cpu.sleeping) begin
                     nxt_r.st  = ST_WAKE;
                     nxt_r.cnt = WAKE_CYC - 3'h1;
                  end else if (cpu.insn_done) begin
                     nxt_r.st  = ST_PUSH;
                     nxt_r.cnt = PUSH_CYC - 3'h1;
                  end else begin
                     nxt_r.st = ST_FINISH;
                  end
               end
            end
            ST_WAKE: begin
               if (r_ff.cnt != RST_CNT) begin
                  nxt_r.cnt = r_ff.cnt - 3'h1;
               end else if (cpu.wake_ready) begin
                  nxt_r.st = ST_FINISH;
               end
            end
            ST_FINISH: begin
               if (cpu.insn_done) begin
                  nxt_r.st  = ST_PUSH;
                  nxt_r.cnt = PUSH_CYC - 3'h1;
               end
            end
            ST_PUSH: begin
               if (r_ff.cnt != RST_CNT) begin
                  nxt_r.cnt = r_ff.cnt - 3'h1;
               end else begin
                  // program counter stored, vector goes out
                  nxt_r.vec.valid  = 1'b1;
                  nxt_r.vec.is_nmi = r_ff.sel_nmi;
                  nxt_r.vec.idx    = r_ff.sel_idx;
                  nxt_r.vec.addr   = 16'(base + 16'(r_ff.sel_idx) * VEC_STRIDE);
                  vclr[r_ff.sel_idx] = src_auto_clear[r_ff.sel_idx];
                  if (r_ff.sel_nmi) begin
                     nxt_r.exec.nmi = 1'b1;
                  end else begin
                     case (r_ff.sel_lvl)
                        LVL_HI:  nxt_r.exec.hi  = 1'b1;
                        LVL_MED: nxt_r.exec.med = 1'b1;
                        default: nxt_r.exec.lo  = 1'b1;
                     endcase
                     if ((r_ff.sel_lvl == LVL_LO) && r_ff.ctrl.rr_en) begin
                        nxt_r.last_lo = 8'(r_ff.sel_idx);
                     end
                  end
                  nxt_r.st  = ST_JUMP;
                  nxt_r.cnt = JUMP_CYC - 3'h1;
               end
            end
            ST_JUMP: begin
               if (r_ff.cnt != RST_CNT) begin
                  nxt_r.cnt = r_ff.cnt - 3'h1;
               end else begin
                  nxt_r.st = ST_IDLE;
               end
            end
            ST_RET: begin
               if (r_ff.cnt != RST_CNT) begin
                  nxt_r.cnt = r_ff.cnt - 3'h1;
               end else begin
                  // the innermost handler is the one returning
                  if (r_ff.exec.nmi) begin
                     nxt_r.exec.nmi = 1'b0;
                  end else if (r_ff.exec.hi) begin
                     nxt_r.exec.hi = 1'b0;
                  end else if (r_ff.exec.med) begin
                     nxt_r.exec.med = 1'b0;
                  end else begin
                     nxt_r.exec.lo = 1'b0;
                  end
                  nxt_r.ret_done = 1'b1;
                  nxt_r.st       = ST_GAP;
               end
            end
            ST_GAP: begin
               if (cpu.insn_done) begin
                  nxt_r.st = ST_IDLE;
               end
            end
            default: nxt_r.st = ST_IDLE;
         endcase
         // new events win over every clear in the same cycle
         nxt_r.pend = (r_ff.pend & ~w1c & ~vclr & ~src_access_clear) | src_event;
         if (reg_wr) begin
            case (reg_addr)
               OFS_LASTLO: nxt_r.last_lo = reg_wdata;
               OFS_CTRL: begin
                  nxt_r.ctrl.rr_en  = reg_wdata[CTRL_RR];
                  nxt_r.ctrl.vsel   = reg_wdata[CTRL_VS];
                  nxt_r.ctrl.hi_en  = reg_wdata[CTRL_HI];
                  nxt_r.ctrl.med_en = reg_wdata[CTRL_MED];
                  nxt_r.ctrl.lo_en  = reg_wdata[CTRL_LO];
               end
               OFS_NMIEN: nxt_r.nmi_en = reg_wdata[N_SRC-1:0];
               default: ;
            endcase
         end
         if (reg_rd) begin
            case (reg_addr)
               OFS_STATUS: begin
                  nxt_r.rdata[STAT_NMI] = r_ff.exec.nmi;
                  nxt_r.rdata[STAT_HI]  = r_ff.exec.hi;
                  nxt_r.rdata[STAT_MED] = r_ff.exec.med;
                  nxt_r.rdata[STAT_LO]  = r_ff.exec.lo;
               end
               OFS_LASTLO: nxt_r.rdata = r_ff.last_lo;
               OFS_CTRL: begin
                  nxt_r.rdata[CTRL_RR]  = r_ff.ctrl.rr_en;
                  nxt_r.rdata[CTRL_VS]  = r_ff.ctrl.vsel;
                  nxt_r.rdata[CTRL_HI]  = r_ff.ctrl.hi_en;
                  nxt_r.rdata[CTRL_MED] = r_ff.ctrl.med_en;
                  nxt_r.rdata[CTRL_LO]  = r_ff.ctrl.lo_en;
               end
               OFS_FLAGS: nxt_r.rdata = r_ff.pend;
               OFS_NMIEN: nxt_r.rdata = r_ff.nmi_en;
               default:   nxt_r.rdata = RST_BYTE;
            endcase
         end
      end
   end

   // ************************************************************
   // state register
   // ************************************************************
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         nxt_r_reset: begin
            r_ff <= '0;
         end
      end else begin
         r_ff <= nxt_r;
      end
   end

   assign reg_rdata     = r_ff.rdata;
   assign vec           = r_ff.vec;
   assign reset_address = r_ff.rst_addr;
   assign ret_done      = r_ff.ret_done;

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn || !ce);

   property p_event_sets;
      src_event[0] |=> r_ff.pend[0];
   endproperty
   a_event_sets: assert property (p_event_sets) else $error("event did not set flag");

   property p_w1c;
      reg_wr && (reg_addr == OFS_FLAGS) |=> (r_ff.pend & $past(reg_wdata & ~src_event)) == 8'h00;
   endproperty
   a_w1c: assert property (p_w1c) else $error("write one did not clear flag");

   property p_unlock_block;
      reg_wr && (reg_addr == OFS_UNLOCK) && (reg_wdata == UNLOCK_SIG) |=> !take [*4];
   endproperty
   a_unlock_block: assert property (p_unlock_block) else $error("ack during unlock block");

   property p_nmi_excl;
      r_ff.exec.nmi |-> !take;
   endproperty
   a_nmi_excl: assert property (p_nmi_excl) else $error("ack under unmaskable handler");

   property p_nmi_flag;
      r_ff.vec.valid && r_ff.vec.is_nmi |-> r_ff.exec.nmi ##0 $past(!r_ff.exec.nmi);
   endproperty
   a_nmi_flag: assert property (p_nmi_flag) else $error("unmaskable flag not set");

   property p_gie;
      take && !take_nmi |-> cpu.gie && (take_lvl > cur_lvl);
   endproperty
   a_gie: assert property (p_gie) else $error("maskable taken without gie or level");

   property p_push_jump;
      $rose(r_ff.st == ST_PUSH) |-> (r_ff.st == ST_PUSH) [*2] ##1
                                    (r_ff.vec.valid && r_ff.st == ST_JUMP) [*1] ##1
                                    (r_ff.st == ST_JUMP) [*2] ##1 (r_ff.st == ST_IDLE);
   endproperty
   a_push_jump: assert property (p_push_jump) else $error("push or jump length wrong");

   property p_ret_len;
      $rose(r_ff.st == ST_RET) |-> (r_ff.st == ST_RET) [*4] ##1 (r_ff.ret_done &&
                                   r_ff.st == ST_GAP);
   endproperty
   a_ret_len: assert property (p_ret_len) else $error("return length wrong");

   property p_gap;
      (r_ff.st == ST_GAP) |-> !take;
   endproperty
   a_gap: assert property (p_gap) else $error("ack before one instruction");

   property p_wake;
      $rose(r_ff.st == ST_WAKE) |-> (r_ff.st == ST_WAKE) [*5];
   endproperty
   a_wake: assert property (p_wake) else $error("wake delay too short");

   property p_lvl_en;
      take && (take_lvl == LVL_HI) |-> r_ff.ctrl.hi_en;
   endproperty
   a_lvl_en: assert property (p_lvl_en) else $error("disabled level taken");

   c_nmi_taken: cover property (take_nmi);
   c_preempt:   cover property (take && r_ff.exec.lo && (take_lvl == LVL_HI));
   c_rotate:    cover property (take && r_ff.ctrl.rr_en && (take_lvl == LVL_LO));
   c_return:    cover property (r_ff.ret_done);

endmodule

// ===== logic/mlc_pick.sv
/*
   priority picker: lowest index first, or rotating start after the last grant.
   assumes a purely combinational use by the controller core.
*/
`timescale 1ns/100ps
module mlc_pick (
   // requests
   input  wire logic [mlc_pkg::N_SRC-1:0] req,
   input  wire logic                      rr_en,
   input  wire logic [7:0]                last,
   // result
   output logic                           found,
   output logic [mlc_pkg::IDX_W-1:0]      idx
);
   import mlc_pkg::*;

   // ************************************************************
   // search
   // ************************************************************
   always_comb begin
      logic [IDX_W-1:0] start;
      logic [IDX_W-1:0] j;
      start = '0;
      j     = '0;
      found = 1'b0;
      idx   = '0;
      // fixed order starts the walk just before index zero
      start = rr_en ? last[IDX_W-1:0] : IDX_W'(N_SRC - 1);
      for (int k = 1; k <= N_SRC; k++) begin
         j = IDX_W'(start + IDX_W'(k));
         if (!found && req[j]) begin
            found = 1'b1;
            idx   = j;
         end
      end
   end

endmodule

// ===== logic/mlc_pkg.sv
/*
   shared constants, types and helper functions of the multilevel request controller.
   assumes a cpu core that reports instruction boundaries, handler returns and sleep state.
*/
package mlc_pkg;

   // ************************************************************
   // sizes
   // ************************************************************
   localparam int N_SRC = 8;
   localparam int IDX_W = 3;

   // ************************************************************
   // register offsets
   // ************************************************************
   localparam logic [7:0] OFS_STATUS = 8'h00;
   localparam logic [7:0] OFS_LASTLO = 8'h01;
   localparam logic [7:0] OFS_CTRL   = 8'h02;
   localparam logic [7:0] OFS_FLAGS  = 8'h03;
   localparam logic [7:0] OFS_UNLOCK = 8'h04;
   localparam logic [7:0] OFS_NMIEN  = 8'h05;

   // ************************************************************
   // field positions
   // ************************************************************
   localparam int STAT_NMI = 7;
   localparam int STAT_HI  = 2;
   localparam int STAT_MED = 1;
   localparam int STAT_LO  = 0;
   localparam int CTRL_RR  = 7;
   localparam int CTRL_VS  = 6;
   localparam int CTRL_HI  = 2;
   localparam int CTRL_MED = 1;
   localparam int CTRL_LO  = 0;

   // ************************************************************
   // levels, vectors, signature
   // ************************************************************
   localparam logic [1:0]  LVL_OFF      = 2'h0;
   localparam logic [1:0]  LVL_LO       = 2'h1;
   localparam logic [1:0]  LVL_MED      = 2'h2;
   localparam logic [1:0]  LVL_HI       = 2'h3;
   localparam logic [15:0] RESET_VEC    = 16'h0000;
   localparam logic [15:0] VEC_BASE_OFS = 16'h0002;
   localparam logic [15:0] VEC_STRIDE   = 16'h0002;
   // arbitrary unlock signature value
   localparam logic [7:0]  UNLOCK_SIG   = 8'hA5;
   localparam logic [7:0]  RST_BYTE     = 8'h00;
   localparam logic [2:0]  RST_CNT      = 3'h0;

   // ************************************************************
   // timing in cpu clock cycles
   // ************************************************************
   localparam int         PC_BITS   = 16;
   localparam logic [2:0] PUSH_CYC  = 3'h2;
   localparam logic [2:0] JUMP_CYC  = 3'h3;
   localparam logic [2:0] WAKE_CYC  = 3'h5;
   localparam logic [2:0] BLOCK_CYC = 3'h4;
   localparam logic [2:0] RET_CYC   = (PC_BITS > 16) ? 3'h5 : 3'h4;

   // ************************************************************
   // types
   // ************************************************************
   typedef logic [N_SRC-1:0][1:0] mlc_lvl_arr_t;

   typedef enum logic [2:0] {ST_IDLE, ST_WAKE, ST_FINISH, ST_PUSH, ST_JUMP, ST_RET,
                             ST_GAP} mlc_state_t;

   typedef struct packed {
      logic rr_en;
      logic vsel;
      logic hi_en;
      logic med_en;
      logic lo_en;
   } mlc_ctrl_t;

   typedef struct packed {
      logic nmi;
      logic hi;
      logic med;
      logic lo;
   } mlc_exec_t;

   typedef struct packed {
      logic gie;
      logic insn_done;
      logic handler_return_instruction;
      logic sleeping;
      logic wake_ready;
   } mlc_cpu_t;

   typedef struct packed {
      logic             valid;
      logic             is_nmi;
      logic [IDX_W-1:0] idx;
      logic [15:0]      addr;
   } mlc_vec_t;

   // ************************************************************
   // functions
   // ************************************************************
   function automatic logic lvl_req(input logic [1:0] lvl, input logic [1:0] want,
                                    input mlc_ctrl_t c);
      logic en;
      en = (want == LVL_HI) ? c.hi_en : (want == LVL_MED) ? c.med_en : c.lo_en;
      return (lvl == want) && (want != LVL_OFF) && en;
   endfunction

   function automatic logic [1:0] exec_level(input mlc_exec_t e);
      return e.hi ? LVL_HI : e.med ? LVL_MED : e.lo ? LVL_LO : LVL_OFF;
   endfunction

endpackage
